// *** core/scs_clock_select.sv ***
// Behaviour
// - reference is ext pin or rtc, by strap
// - programmable pll multiplier drives system clock
// - strap low: multiply rtc by 375
// - strap high: bypass generator, use ext pin
// - usb boot attempt programs about 36 mhz
// - rtc off: rtc register range inaccessible
// - after boot software may reprogram clocks
// - wait 200 ms settling before running code
// - gating and reset registers at fixed addresses
// - reset gates all clocks; counter-driven peripheral resets
`timescale 1ns/100ps
module scs_clock_select #(
  parameter int SETTLE_CYCLES = scs_pkg::SETTLE_CYCLES,
  parameter int RST_CNT_W = 16
) (
  input wire logic mclk, // 250 mhz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic clk_sel_pin, // reference select strap
  input wire logic rtc_osc_ok, // rtc oscillator running
  input wire logic boot_usb_try, // firmware is trying usb boot
  input wire logic boot_load_done, // pulse: image loaded
  input wire logic [15:0] idle_state_in, // idle state of domains
  input wire logic [7:0] clk_stop_ack, // peripheral stop acknowledges
  input wire logic [15:0] io_addr, // cpu i/o word address
  input wire logic io_rd, // read strobe
  input wire logic io_wr, // write strobe
  input wire logic [15:0] io_wdata, // write data
  output logic [15:0] io_rdata, // read data
  output logic io_ack, // pulse: access done
  output logic rtc_sel, // pulse: forwarded rtc access
  output logic ref_sel_ext, // 1: ext_ref_clock_in, 0: rtc osc
  output scs_pkg::scs_pll_cfg_t pll_cfg, // clock generator setting
  output logic code_run_ok, // settling elapsed
  output logic [31:0] periph_clk_gate, // 1: clock gated off
  output logic [15:0] periph_rst, // peripheral resets held
  output logic [15:0] idle_control, // idle domain requests
  output logic [15:0] ext_mem_clock_divider, // emif clock divider
  output logic [15:0] usb_system_control, // usb system control
  output logic [7:0] clk_stop_req // peripheral stop requests
);
  // pins crossing in from the board
  logic strap_s1, strap_s2, rtc_s1, rtc_s2;
  logic strap_ext;

  scs_pkg::scs_boot_state_t state, next_state;
  logic [31:0] settle_cnt;
  logic [15:0] soft_rst_cnt;
  logic [15:0] rst_ctrl;
  logic [RST_CNT_W-1:0] rst_timer;
  logic rst_busy;

  always_ff @(posedge mclk) begin
    strap_s1 <= clk_sel_pin;
    strap_s2 <= strap_s1;
    rtc_s1 <= rtc_osc_ok;
    rtc_s2 <= rtc_s1;
  end

  // latched only while reset is held, so the source never switches in service
  always_ff @(posedge mclk) begin
    if (srst) begin
      strap_ext <= strap_s2;
    end
  end

  // address decode
  wire in_rtc = (io_addr >= scs_pkg::ADDR_RTC_FIRST) && (io_addr <= scs_pkg::ADDR_RTC_LAST);
  wire wr_idle = io_wr && (io_addr == scs_pkg::ADDR_IDLE_CONTROL);
  wire wr_pcg1 = io_wr && (io_addr == scs_pkg::ADDR_PCG_1);
  wire wr_pcg2 = io_wr && (io_addr == scs_pkg::ADDR_PCG_2);
  wire wr_srcnt = io_wr && (io_addr == scs_pkg::ADDR_SOFT_RST_CNT);
  wire wr_rctrl = io_wr && (io_addr == scs_pkg::ADDR_RST_CTRL);
  wire wr_emif = io_wr && (io_addr == scs_pkg::ADDR_EMIF_DIV);
  wire wr_usb = io_wr && (io_addr == scs_pkg::ADDR_USB_SYS_CTRL);
  wire wr_stop = io_wr && (io_addr == scs_pkg::ADDR_CLK_STOP);
  // generator locked until boot is over so boot config cannot move the clock
  wire sw_clk_ok = (state == scs_pkg::SCS_BOOT_RUN);
  wire wr_mult = io_wr && sw_clk_ok && (io_addr == scs_pkg::ADDR_PLL_MULT);
  wire wr_pctl = io_wr && sw_clk_ok && (io_addr == scs_pkg::ADDR_PLL_CTRL);
  wire rtc_open = rtc_s2 && in_rtc;

  // boot clock sequencer
  always_comb begin
    next_state = state;
    case (state)
      scs_pkg::SCS_BOOT_PROGRAM: next_state = scs_pkg::SCS_BOOT_PROBE;
      scs_pkg::SCS_BOOT_PROBE: begin
        if (boot_load_done) begin
          next_state = scs_pkg::SCS_BOOT_SETTLE;
        end else if (boot_usb_try) begin
          next_state = scs_pkg::SCS_BOOT_USB;
        end
      end
      scs_pkg::SCS_BOOT_USB: begin
        if (boot_load_done) begin
          next_state = scs_pkg::SCS_BOOT_SETTLE;
        end
      end
      scs_pkg::SCS_BOOT_SETTLE: begin
        if (settle_cnt == 32'(SETTLE_CYCLES - 1)) begin
          next_state = scs_pkg::SCS_BOOT_RUN;
        end
      end
      scs_pkg::SCS_BOOT_RUN: next_state = scs_pkg::SCS_BOOT_RUN;
      default: next_state = scs_pkg::SCS_BOOT_PROGRAM;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= scs_pkg::SCS_BOOT_PROGRAM;
      settle_cnt <= '0;
      code_run_ok <= 1'b0;
    end else begin
      state <= next_state;
      if (state == scs_pkg::SCS_BOOT_SETTLE) begin
        settle_cnt <= settle_cnt + 32'd1;
      end
      code_run_ok <= (next_state == scs_pkg::SCS_BOOT_RUN);
    end
  end

  // reference select and generator programming
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_sel_ext <= 1'b0;
      pll_cfg.mult <= scs_pkg::MULT_RESET;
      pll_cfg.bypass <= 1'b1; // generator starts bypassed
      pll_cfg.powered <= 1'b0;
    end else begin
      ref_sel_ext <= strap_ext;
      if (state == scs_pkg::SCS_BOOT_PROGRAM) begin
        if (strap_ext) begin
          pll_cfg.bypass <= 1'b1;
          pll_cfg.powered <= 1'b0;
        end else begin
          pll_cfg.mult <= scs_pkg::MULT_RTC_BOOT;
          pll_cfg.bypass <= 1'b0;
          pll_cfg.powered <= 1'b1;
        end
      end else if (state == scs_pkg::SCS_BOOT_PROBE && next_state == scs_pkg::SCS_BOOT_USB) begin
        // about 36 mhz from either reference
        pll_cfg.mult <= strap_ext ? scs_pkg::MULT_EXT_USB : scs_pkg::MULT_RTC_USB;
        pll_cfg.bypass <= 1'b0;
        pll_cfg.powered <= 1'b1;
      end else begin
        if (wr_mult) begin
          pll_cfg.mult <= io_wdata[scs_pkg::MULT_W-1:0];
        end
        if (wr_pctl) begin
          pll_cfg.bypass <= io_wdata[scs_pkg::PLL_CTRL_BYPASS_BIT];
          pll_cfg.powered <= io_wdata[scs_pkg::PLL_CTRL_POWER_BIT];
        end
      end
    end
  end

  // plain system registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      periph_clk_gate <= {scs_pkg::RST_PCG, scs_pkg::RST_PCG};
      idle_control <= scs_pkg::RST_IDLE_CONTROL;
      ext_mem_clock_divider <= scs_pkg::RST_EMIF_DIV;
      usb_system_control <= scs_pkg::RST_USB_SYS_CTRL;
      clk_stop_req <= '0;
      soft_rst_cnt <= scs_pkg::RST_SOFT_RST_CNT;
    end else begin
      if (wr_pcg1) begin
        periph_clk_gate[15:0] <= io_wdata;
      end
      if (wr_pcg2) begin
        periph_clk_gate[31:16] <= io_wdata;
      end
      if (wr_idle) begin
        idle_control <= io_wdata;
      end
      if (wr_emif) begin
        ext_mem_clock_divider <= io_wdata;
      end
      if (wr_usb) begin
        usb_system_control <= io_wdata;
      end
      if (wr_stop) begin
        clk_stop_req <= io_wdata[scs_pkg::CLK_STOP_REQ_LSB +: 8];
      end
      if (wr_srcnt) begin
        soft_rst_cnt <= io_wdata;
      end
    end
  end

  // peripheral resets: control bits hold their resets for the counted
  // number of cycles plus two, then clear themselves; a write while busy is merged
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_ctrl <= '0;
      rst_timer <= '0;
      rst_busy <= 1'b0;
      periph_rst <= '0;
    end else begin
      if (wr_rctrl && io_wdata != 16'h0000) begin
        rst_ctrl <= rst_ctrl | io_wdata;
        rst_timer <= soft_rst_cnt[RST_CNT_W-1:0];
        rst_busy <= 1'b1;
      end else if (rst_busy) begin
        if (rst_timer == '0) begin
          rst_ctrl <= '0;
          rst_busy <= 1'b0;
        end else begin
          rst_timer <= rst_timer - 1'b1;
        end
      end
      periph_rst <= (wr_rctrl ? (rst_ctrl | io_wdata) : rst_ctrl);
    end
  end

  // read side; unmapped and locked-out rtc words read as zero
  logic [15:0] rd_mux;
  always_comb begin
    case (io_addr)
      scs_pkg::ADDR_IDLE_CONTROL: rd_mux = idle_control;
      scs_pkg::ADDR_IDLE_STATUS: rd_mux = idle_state_in;
      scs_pkg::ADDR_PCG_1: rd_mux = periph_clk_gate[15:0];
      scs_pkg::ADDR_PCG_2: rd_mux = periph_clk_gate[31:16];
      scs_pkg::ADDR_SOFT_RST_CNT: rd_mux = soft_rst_cnt;
      scs_pkg::ADDR_RST_CTRL: rd_mux = rst_ctrl;
      scs_pkg::ADDR_PLL_MULT: rd_mux = 16'(pll_cfg.mult);
      scs_pkg::ADDR_PLL_CTRL: rd_mux = {14'h0000, pll_cfg.powered, pll_cfg.bypass};
      scs_pkg::ADDR_BOOT_STATUS: rd_mux = {13'h0000, rtc_s2, code_run_ok, ref_sel_ext};
      scs_pkg::ADDR_EMIF_DIV: rd_mux = ext_mem_clock_divider;
      scs_pkg::ADDR_USB_SYS_CTRL: rd_mux = usb_system_control;
      scs_pkg::ADDR_CLK_STOP: rd_mux = {clk_stop_ack, clk_stop_req};
      default: rd_mux = scs_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      io_rdata <= '0;
      io_ack <= 1'b0;
      rtc_sel <= 1'b0;
    end else begin
      io_ack <= io_rd || io_wr;
      io_rdata <= io_rd ? rd_mux : 16'h0000;
      rtc_sel <= (io_rd || io_wr) && rtc_open;
    end
  end
endmodule : scs_clock_select

// *** core/scs_pkg.sv ***
package scs_pkg;
  // word addresses on the cpu i/o port
  localparam logic [15:0] ADDR_IDLE_CONTROL = 16'h0001;
  localparam logic [15:0] ADDR_IDLE_STATUS = 16'h0002;
  localparam logic [15:0] ADDR_PCG_1 = 16'h1c02;
  localparam logic [15:0] ADDR_PCG_2 = 16'h1c03;
  localparam logic [15:0] ADDR_SOFT_RST_CNT = 16'h1c04;
  localparam logic [15:0] ADDR_RST_CTRL = 16'h1c05;
  localparam logic [15:0] ADDR_PLL_MULT = 16'h1c20;
  localparam logic [15:0] ADDR_PLL_CTRL = 16'h1c21;
  localparam logic [15:0] ADDR_BOOT_STATUS = 16'h1c22;
  localparam logic [15:0] ADDR_EMIF_DIV = 16'h1c26;
  localparam logic [15:0] ADDR_USB_SYS_CTRL = 16'h1c32;
  localparam logic [15:0] ADDR_CLK_STOP = 16'h1c3a;
  localparam logic [15:0] ADDR_RTC_FIRST = 16'h1900;
  localparam logic [15:0] ADDR_RTC_LAST = 16'h197f;

  // reset values: a set gate bit means that peripheral clock is off
  localparam logic [15:0] RST_PCG = 16'hffff;
  localparam logic [15:0] RST_IDLE_CONTROL = 16'h0000;
  localparam logic [15:0] RST_SOFT_RST_CNT = 16'h0008;
  localparam logic [15:0] RST_EMIF_DIV = 16'h0001;
  localparam logic [15:0] RST_USB_SYS_CTRL = 16'h0000;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // pll control register fields
  localparam int PLL_CTRL_BYPASS_BIT = 0;
  localparam int PLL_CTRL_POWER_BIT = 1;
  // clock stop register: requests low byte, acknowledges high byte
  localparam int CLK_STOP_REQ_LSB = 0;
  localparam int CLK_STOP_ACK_LSB = 8;

  // pll multiplier settings used at boot
  localparam int MULT_W = 11;
  localparam logic [MULT_W-1:0] MULT_RESET = 11'h001;
  localparam logic [MULT_W-1:0] MULT_RTC_BOOT = 11'h177; // 375 x 32.768 kHz
  localparam logic [MULT_W-1:0] MULT_RTC_USB = 11'h465; // 1125 x 32.768 kHz
  localparam logic [MULT_W-1:0] MULT_EXT_USB = 11'h003; // 3 x ext ref

  // settling wait
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_MS = 200;
  localparam int SETTLE_CYCLES = SETTLE_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SCS_BOOT_PROGRAM,
    SCS_BOOT_PROBE,
    SCS_BOOT_USB,
    SCS_BOOT_SETTLE,
    SCS_BOOT_RUN
  } scs_boot_state_t;

  typedef struct packed {
    logic [MULT_W-1:0] mult;
    logic bypass;
    logic powered;
  } scs_pll_cfg_t;
endpackage : scs_pkg

// *** tb/scs_board_model.sv ***
`timescale 1ns/100ps
module scs_board_model (
  input wire logic mclk, // clock
  input wire logic strap, // board strap level
  input wire logic rtc_on, // crystal fitted
  input wire logic usb_req, // firmware tries usb
  input wire logic load_req, // image found
  output logic clk_sel_pin, // strap pin
  output logic rtc_osc_ok, // rtc running
  output logic boot_usb_try, // usb attempt
  output logic boot_load_done // one-cycle pulse
);
  // bypass reference is taken as one of the three allowed rates
  localparam int EXT_REF_HZ = 12288000;
  logic load_q = 1'b0;
  assign clk_sel_pin = strap;
  assign rtc_osc_ok = rtc_on;
  assign boot_usb_try = usb_req;
  // firmware reports the load once, however long the request stays up
  // image carries no timer settings, so the settle count starts clean
  assign boot_load_done = load_req && !load_q;
  always @(posedge mclk) begin
    load_q <= load_req;
  end
endmodule : scs_board_model

// *** tb/scs_properties.sv ***
`timescale 1ns/100ps
module scs_properties #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic mclk, // clock
  input wire logic srst, // reset
  input wire logic rtc_osc_ok, // rtc running
  input wire logic boot_usb_try, // usb try
  input wire logic boot_load_done, // load pulse
  input wire logic [15:0] io_addr, // address
  input wire logic io_rd, // read
  input wire logic io_wr, // write
  input wire logic [15:0] io_wdata, // write data
  input wire logic io_ack, // ack
  input wire logic rtc_sel, // rtc forward
  input wire logic ref_sel_ext, // reference
  input wire scs_pkg::scs_pll_cfg_t pll_cfg, // pll setting
  input wire logic code_run_ok, // settled
  input wire logic [31:0] periph_clk_gate, // gates
  input wire logic [15:0] periph_rst // resets
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [31:0] since_load;
  wire in_rtc = io_addr >= scs_pkg::ADDR_RTC_FIRST && io_addr <= scs_pkg::ADDR_RTC_LAST;
  always_ff @(posedge mclk) begin
    if (srst || boot_load_done) since_load <= 32'h0;
    else since_load <= since_load + 32'h1;
  end
  property p_ack; (io_rd || io_wr) |=> io_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_rtc_off; !rtc_osc_ok [*4] |-> !rtc_sel; endproperty
  a_rtc_off: assert property (p_rtc_off) else $error("rtc access while off");
  property p_rtc_on; rtc_osc_ok [*4] ##0 (io_rd || io_wr) && in_rtc |=> rtc_sel; endproperty
  a_rtc_on: assert property (p_rtc_on) else $error("rtc access not forwarded");
  property p_gate;
    io_wr && io_addr == scs_pkg::ADDR_PCG_1 |=> periph_clk_gate[15:0] == $past(io_wdata);
  endproperty
  a_gate: assert property (p_gate) else $error("gate write lost");
  property p_gate_rst; $fell(srst) |-> periph_clk_gate == 32'hffffffff && periph_rst == 16'h0; endproperty
  a_gate_rst: assert property (p_gate_rst) else $error("clocks not off at reset");
  property p_strap_hold; !$past(srst) && !$past(srst, 2) |-> $stable(ref_sel_ext); endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("reference changed");
  property p_boot_cfg;
    $fell(srst) |-> ##2 (ref_sel_ext ? (pll_cfg.bypass && !pll_cfg.powered)
      : (pll_cfg.mult == scs_pkg::MULT_RTC_BOOT && !pll_cfg.bypass && pll_cfg.powered));
  endproperty
  a_boot_cfg: assert property (p_boot_cfg) else $error("boot pll setting wrong");
  property p_settle; $rose(code_run_ok) |-> since_load >= SETTLE_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("run before settling");
  property p_prst;
    io_wr && io_addr == scs_pkg::ADDR_RST_CTRL && io_wdata != 16'h0
      |=> (periph_rst & $past(io_wdata)) == $past(io_wdata);
  endproperty
  a_prst: assert property (p_prst) else $error("peripheral reset not held");
  property p_lock;
    io_wr && io_addr == scs_pkg::ADDR_PLL_MULT && !code_run_ok && !boot_usb_try |=> $stable(pll_cfg);
  endproperty
  a_lock: assert property (p_lock) else $error("pll changed during boot");
endmodule : scs_properties

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b0, rtc_on = 1'b1, usb_req = 1'b0, load_req = 1'b0;
  logic clk_sel_pin, rtc_osc_ok, boot_usb_try, boot_load_done;
  logic [15:0] idle_state_in = 16'h5a3c;
  logic [7:0] clk_stop_ack = 8'h81;
  logic [15:0] io_addr = 16'h0, io_wdata = 16'h0, io_rdata, periph_rst;
  logic [15:0] idle_control, ext_mem_clock_divider, usb_system_control;
  logic io_rd = 1'b0, io_wr = 1'b0, io_ack, rtc_sel, ref_sel_ext, code_run_ok;
  scs_pkg::scs_pll_cfg_t pll_cfg;
  logic [31:0] periph_clk_gate;
  logic [7:0] clk_stop_req;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  initial begin
    forever #2 mclk = ~mclk;
  end
  scs_clock_select #(.SETTLE_CYCLES(20)) uut (.mclk, .srst, .clk_sel_pin, .rtc_osc_ok,
    .boot_usb_try, .boot_load_done, .idle_state_in, .clk_stop_ack, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .io_ack, .rtc_sel, .ref_sel_ext, .pll_cfg, .code_run_ok,
    .periph_clk_gate, .periph_rst, .idle_control, .ext_mem_clock_divider,
    .usb_system_control, .clk_stop_req);
  scs_board_model board (.mclk, .strap, .rtc_on, .usb_req, .load_req, .clk_sel_pin,
    .rtc_osc_ok, .boot_usb_try, .boot_load_done);
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one-cycle strobe; ack and read data land one cycle later
  task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_rd <= rd;
    io_wr <= !rd;
    @(posedge mclk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    #1;
    chk("ack", io_ack, 16'h1);
  endtask : acc
  task automatic rdchk(input string nm, input logic [15:0] a, input logic [15:0] exp);
    acc(1'b1, a, 16'h0);
    chk(nm, io_rdata, exp);
  endtask : rdchk
  task automatic boot(input logic s);
    srst <= 1'b1;
    strap <= s;
    usb_req <= 1'b0;
    load_req <= 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : boot
  task automatic try_usb(input logic [15:0] exp);
    @(posedge mclk) usb_req <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("usb mult", pll_cfg.mult, exp);
  endtask : try_usb
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    boot(1'b0);
    chk("ref", ref_sel_ext, 16'h0);
    chk("boot pll", {pll_cfg.mult, pll_cfg.bypass, pll_cfg.powered}, 16'h05dd);
    rdchk("gate1", scs_pkg::ADDR_PCG_1, scs_pkg::RST_PCG);
    rdchk("gate2", scs_pkg::ADDR_PCG_2, scs_pkg::RST_PCG);
    rdchk("cnt", scs_pkg::ADDR_SOFT_RST_CNT, scs_pkg::RST_SOFT_RST_CNT);
    rdchk("emif", scs_pkg::ADDR_EMIF_DIV, scs_pkg::RST_EMIF_DIV);
    rdchk("idle", scs_pkg::ADDR_IDLE_STATUS, idle_state_in);
    rdchk("hole", 16'h1c01, 16'h0);
    acc(1'b0, scs_pkg::ADDR_PLL_MULT, 16'h0005);
    chk("locked", pll_cfg.mult, scs_pkg::MULT_RTC_BOOT);
    try_usb(scs_pkg::MULT_RTC_USB);
    @(posedge mclk) load_req <= 1'b1;
    // load pulse seen one edge later, then 20 settle counts
    repeat (20) @(posedge mclk);
    #1 chk("early", code_run_ok, 16'h0);
    @(posedge mclk);
    #1 chk("run", code_run_ok, 16'h1);
    acc(1'b0, scs_pkg::ADDR_PLL_MULT, 16'h0100);
    chk("reprog", pll_cfg.mult, 16'h0100);
    acc(1'b0, scs_pkg::ADDR_PLL_CTRL, 16'h0001);
    chk("pll ctrl", {pll_cfg.bypass, pll_cfg.powered}, 16'h2);
    rdchk("status", scs_pkg::ADDR_BOOT_STATUS, 16'h0006);
    acc(1'b0, scs_pkg::ADDR_PCG_1, 16'h1234);
    rdchk("gate1 rw", scs_pkg::ADDR_PCG_1, 16'h1234);
    acc(1'b0, scs_pkg::ADDR_IDLE_CONTROL, 16'h00ff);
    chk("idle out", idle_control, 16'h00ff);
    rdchk("idle rw", scs_pkg::ADDR_IDLE_CONTROL, 16'h00ff);
    acc(1'b0, scs_pkg::ADDR_EMIF_DIV, 16'h0004);
    chk("emif out", ext_mem_clock_divider, 16'h0004);
    acc(1'b0, scs_pkg::ADDR_USB_SYS_CTRL, 16'h0003);
    chk("usb out", usb_system_control, 16'h0003);
    rdchk("usb rw", scs_pkg::ADDR_USB_SYS_CTRL, 16'h0003);
    acc(1'b0, scs_pkg::ADDR_CLK_STOP, 16'hffa5);
    chk("stop out", clk_stop_req, 16'h00a5);
    rdchk("stop", scs_pkg::ADDR_CLK_STOP, 16'h81a5);
    acc(1'b0, scs_pkg::ADDR_SOFT_RST_CNT, 16'h0002);
    acc(1'b0, scs_pkg::ADDR_RST_CTRL, 16'h0003);
    chk("prst on", periph_rst, 16'h0003);
    repeat (3) @(posedge mclk);
    #1 chk("prst held", periph_rst, 16'h0003);
    @(posedge mclk);
    #1 chk("prst off", periph_rst, 16'h0);
    rdchk("rtc data", 16'h1900, 16'h0);
    chk("rtc fwd", rtc_sel, 16'h1);
    @(posedge mclk) rtc_on <= 1'b0;
    repeat (4) @(posedge mclk);
    acc(1'b1, 16'h197f, 16'h0);
    chk("rtc off", rtc_sel, 16'h0);
    @(posedge mclk);
    boot(1'b1);
    chk("ref ext", ref_sel_ext, 16'h1);
    chk("not run", code_run_ok, 16'h0);
    rdchk("gate1 rst", scs_pkg::ADDR_PCG_1, scs_pkg::RST_PCG);
    chk("bypass", {pll_cfg.bypass, pll_cfg.powered}, 16'h2);
    try_usb(scs_pkg::MULT_EXT_USB);
    complete_run;
  end
endmodule : testbench
bind scs_clock_select scs_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.mclk, .srst,
  .rtc_osc_ok, .boot_usb_try, .boot_load_done, .io_addr, .io_rd, .io_wr, .io_wdata, .io_ack,
  .rtc_sel, .ref_sel_ext, .pll_cfg, .code_run_ok, .periph_clk_gate, .periph_rst);
